// ---- design/dmp_pkg.sv ----
package dmp_pkg;
    // ==============================
    // Sizes
    localparam int CHANNELS = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int LOW_ADDR_W = 4;
    localparam int MID_ADDR_W = 4;
    // ==============================
    // Transfer types
    typedef enum logic [1:0] {
        DMP_XFER_VERIFY = 2'b00,
        DMP_XFER_WRITE = 2'b01,
        DMP_XFER_READ = 2'b10,
        DMP_XFER_MEM2MEM = 2'b11
    } dmp_xfer_type;
    // ==============================
    // Cycle states
    typedef enum logic [2:0] {
        DMP_ST_IDLE = 3'b000,
        DMP_ST_WAIT = 3'b001,
        DMP_ST_ADDR = 3'b010,
        DMP_ST_READ = 3'b011,
        DMP_ST_WRITE = 3'b100,
        DMP_ST_DONE = 3'b101
    } dmp_state_type;
    // ==============================
    // Reset values and other constants
    localparam logic [3:0] MASK_RESET = 4'h0_00f;
    localparam logic [3:0] ACK_POL_RESET = 4'h0_000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int EOP_PULSE_CYCLES = 1;
    localparam int SYNC_STAGES = 2;
    localparam int BUF_DEPTH = 2;
endpackage

// ---- design/dmp_word_if.sv ----
`timescale 1ns/100ps
interface dmp_word_if;
    import dmp_pkg::*;
    logic valid;
    logic ready;
    logic [DATA_W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ---- design/dmp_skid_buffer.sv ----
`timescale 1ns/100ps
module dmp_skid_buffer (
    input wire logic core_clk,
    input wire logic rst_b,
    dmp_word_if.sink in_side,
    dmp_word_if.source out_side
);
    import dmp_pkg::*;

    // ==============================
    // Two-entry ring buffer
    logic [DATA_W-1:0] mem_reg [BUF_DEPTH];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign in_side.ready = (count_reg != 2'd2);
    assign out_side.valid = (count_reg != 2'd0);
    assign out_side.data = mem_reg[rd_ptr_reg];
    assign push = in_side.valid && in_side.ready;
    assign pop = out_side.valid && out_side.ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_side.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // dmp_skid_buffer

// ---- design/dmp_eop_sync.sv ----
`timescale 1ns/100ps
module dmp_eop_sync (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic eop_pin_in,
    output logic eop_low_sync
);
    import dmp_pkg::*;

    // ==============================
    // Two-flop synchroniser, idle high
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= eop_pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign eop_low_sync = ~sync_reg;
endmodule // dmp_eop_sync

// ---- design/dmp_bus_master.sv ----
`timescale 1ns/100ps
module dmp_bus_master (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [dmp_pkg::CHANNELS-1:0] channel_request,
    input wire logic [dmp_pkg::CHANNELS-1:0] software_request,
    input wire logic [dmp_pkg::CHANNELS-1:0] mask_set,
    input wire logic [dmp_pkg::CHANNELS-1:0] mask_clear,
    input wire logic [dmp_pkg::CHANNELS-1:0] autoinit_enable,
    input wire logic [dmp_pkg::CHANNELS-1:0] ack_active_high,
    input wire logic [dmp_pkg::CHANNELS-1:0] status_clear,
    input wire logic mem_to_mem_enable,
    input wire logic block_mode,
    input wire dmp_pkg::dmp_xfer_type xfer_type,
    input wire logic base_load,
    input wire logic [1:0] base_channel,
    input wire logic [dmp_pkg::ADDR_W-1:0] base_address,
    input wire logic [dmp_pkg::ADDR_W-1:0] base_count,
    input wire logic hold_acknowledge,
    input wire logic end_of_process_n_in,
    output logic end_of_process_n_oe,
    output logic end_of_process_n_out,
    input wire logic [dmp_pkg::LOW_ADDR_W-1:0] low_address_lines_in,
    output logic [dmp_pkg::LOW_ADDR_W-1:0] low_address_lines_out,
    output logic low_address_lines_oe,
    output logic [dmp_pkg::MID_ADDR_W-1:0] mid_address_lines,
    output logic mid_address_lines_oe,
    input wire logic [dmp_pkg::DATA_W-1:0] data_lines_in,
    output logic [dmp_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    output logic hold_request,
    output logic [dmp_pkg::CHANNELS-1:0] channel_acknowledge,
    output logic upper_address_enable,
    output logic upper_address_strobe,
    output logic memory_read_n,
    output logic memory_write_n,
    output logic control_oe,
    output logic [dmp_pkg::LOW_ADDR_W-1:0] register_select,
    output logic [dmp_pkg::CHANNELS-1:0] mask_status,
    output logic [dmp_pkg::CHANNELS-1:0] terminal_count,
    output logic busy
);
    import dmp_pkg::*;

    // ==============================
    // Helpers
    function automatic logic [1:0] pick_channel(input logic [CHANNELS-1:0] req);
        logic [1:0] ch;
        ch = 2'd0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (req[i]) begin
                ch = 2'(i);
            end
        end
        return ch;
    endfunction

    function automatic logic [CHANNELS-1:0] one_hot(input logic [1:0] ch);
        return 4'(1) << ch;
    endfunction

    // ==============================
    // State
    dmp_state_type state_reg;
    logic [1:0] chan_reg;
    logic [1:0] src_phase_reg;
    logic [ADDR_W-1:0] base_addr_reg [CHANNELS];
    logic [ADDR_W-1:0] base_cnt_reg [CHANNELS];
    logic [ADDR_W-1:0] cur_addr_reg [CHANNELS];
    logic [ADDR_W-1:0] cur_cnt_reg [CHANNELS];
    logic [DATA_W-1:0] last_upper_reg;
    logic upper_valid_reg;
    logic [CHANNELS-1:0] mask_reg;
    logic [CHANNELS-1:0] tc_reg;
    logic eop_drive_reg;
    logic eop_low_sync;
    logic [CHANNELS-1:0] pending;
    logic [1:0] xfer_ch;
    logic [ADDR_W-1:0] xfer_addr;
    logic at_tc;
    logic finish;
    logic suppress_pulse;
    logic hold_req_next;

    // Temporary byte path for memory-to-memory
    dmp_word_if tmp_in ();
    dmp_word_if tmp_out ();

    dmp_skid_buffer u_tmp (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_side(tmp_in.sink),
        .out_side(tmp_out.source)
    );

    dmp_eop_sync u_eop (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .eop_pin_in(end_of_process_n_in),
        .eop_low_sync(eop_low_sync)
    );

    assign pending = (channel_request & ~mask_reg) | software_request;
    assign xfer_ch = (mem_to_mem_enable && src_phase_reg == 2'd1) ? 2'd1 : chan_reg;
    assign xfer_addr = cur_addr_reg[xfer_ch];
    assign at_tc = (cur_cnt_reg[xfer_ch] == ZERO_WORD);
    // Channel 0 in memory-to-memory never signals; channel 1 does
    assign suppress_pulse = mem_to_mem_enable && (xfer_ch == 2'd0);
    assign finish = (state_reg == DMP_ST_WRITE) && ((at_tc && !suppress_pulse) || eop_low_sync
        || !block_mode);
    // Capture while the read strobe is low, one state after the read state
    assign tmp_in.valid = (state_reg == DMP_ST_WRITE) && mem_to_mem_enable
        && (src_phase_reg == 2'd0);
    assign tmp_in.data = data_lines_in;
    assign tmp_out.ready = (state_reg == DMP_ST_WRITE) && mem_to_mem_enable
        && (src_phase_reg == 2'd1);

    // ==============================
    // Cycle sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= DMP_ST_IDLE;
            chan_reg <= 2'd0;
            src_phase_reg <= 2'd0;
            upper_valid_reg <= 1'b0;
            last_upper_reg <= ZERO_BYTE;
        end else begin
            unique case (state_reg)
                DMP_ST_IDLE: begin
                    upper_valid_reg <= 1'b0;
                    src_phase_reg <= 2'd0;
                    if (pending != 4'h0_000) begin
                        chan_reg <= mem_to_mem_enable ? 2'd0 : pick_channel(pending);
                        state_reg <= DMP_ST_WAIT;
                    end
                end
                DMP_ST_WAIT: begin
                    if (hold_acknowledge) begin
                        state_reg <= DMP_ST_ADDR;
                    end
                end
                DMP_ST_ADDR: begin
                    upper_valid_reg <= 1'b1;
                    last_upper_reg <= xfer_addr[15:8];
                    state_reg <= DMP_ST_READ;
                end
                DMP_ST_READ: begin
                    if (!mem_to_mem_enable || tmp_in.ready) begin
                        state_reg <= DMP_ST_WRITE;
                    end
                end
                DMP_ST_WRITE: begin
                    if (mem_to_mem_enable && src_phase_reg == 2'd0) begin
                        src_phase_reg <= 2'd1;
                        state_reg <= DMP_ST_READ;
                    end else if (finish || eop_low_sync) begin
                        state_reg <= DMP_ST_DONE;
                    end else if (mem_to_mem_enable) begin
                        src_phase_reg <= 2'd0;
                        state_reg <= DMP_ST_READ;
                    end else if (cur_addr_reg[chan_reg][15:8] + 8'h01 != last_upper_reg
                        && cur_addr_reg[chan_reg][7:0] == 8'hff) begin
                        state_reg <= DMP_ST_ADDR;
                    end else begin
                        state_reg <= DMP_ST_READ;
                    end
                end
                DMP_ST_DONE: begin
                    state_reg <= DMP_ST_IDLE;
                end
                default: begin
                    state_reg <= DMP_ST_IDLE;
                end
            endcase
        end
    end

    // ==============================
    // Address and count registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < CHANNELS; i++) begin
                base_addr_reg[i] <= ZERO_WORD;
                base_cnt_reg[i] <= ZERO_WORD;
                cur_addr_reg[i] <= ZERO_WORD;
                cur_cnt_reg[i] <= ZERO_WORD;
            end
        end else begin
            if (base_load && state_reg == DMP_ST_IDLE) begin
                base_addr_reg[base_channel] <= base_address;
                base_cnt_reg[base_channel] <= base_count;
                cur_addr_reg[base_channel] <= base_address;
                cur_cnt_reg[base_channel] <= base_count;
            end
            if (state_reg == DMP_ST_WRITE) begin
                cur_addr_reg[xfer_ch] <= xfer_addr + 16'h0001;
                cur_cnt_reg[xfer_ch] <= cur_cnt_reg[xfer_ch] - 16'h0001;
            end
            if (state_reg == DMP_ST_DONE) begin
                for (int i = 0; i < CHANNELS; i++) begin
                    if (autoinit_enable[i] && (i == chan_reg
                        || (mem_to_mem_enable && i == 1))) begin
                        cur_addr_reg[i] <= base_addr_reg[i];
                        cur_cnt_reg[i] <= base_cnt_reg[i];
                    end
                end
            end
        end
    end

    // ==============================
    // Mask and status bits
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= MASK_RESET;
            tc_reg <= 4'h0_000;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (state_reg == DMP_ST_DONE && (i == chan_reg
                    || (mem_to_mem_enable && i == 1))) begin
                    tc_reg[i] <= 1'b1;
                    mask_reg[i] <= !autoinit_enable[i];
                end else begin
                    if (status_clear[i]) begin
                        tc_reg[i] <= 1'b0;
                    end
                    if (mask_set[i]) begin
                        mask_reg[i] <= 1'b1;
                    end else if (mask_clear[i]) begin
                        mask_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ==============================
    // End of process output
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            eop_drive_reg <= 1'b0;
        end else begin
            eop_drive_reg <= (state_reg == DMP_ST_WRITE) && at_tc && !suppress_pulse
                && !(mem_to_mem_enable && src_phase_reg == 2'd0);
        end
    end

    assign end_of_process_n_out = 1'b0;
    assign end_of_process_n_oe = eop_drive_reg;

    // ==============================
    // Pin drivers
    assign hold_req_next = (state_reg != DMP_ST_IDLE && state_reg != DMP_ST_DONE)
        || (pending != 4'h0_000);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_request <= 1'b0;
            channel_acknowledge <= ~ACK_POL_RESET;
            upper_address_enable <= 1'b0;
            upper_address_strobe <= 1'b0;
            memory_read_n <= 1'b1;
            memory_write_n <= 1'b1;
            control_oe <= 1'b0;
            low_address_lines_out <= 4'h0_000;
            low_address_lines_oe <= 1'b0;
            mid_address_lines <= 4'h0_000;
            mid_address_lines_oe <= 1'b0;
            data_lines_out <= ZERO_BYTE;
            data_lines_oe <= 1'b0;
            register_select <= 4'h0_000;
            busy <= 1'b0;
        end else begin
            logic active;
            active = (state_reg == DMP_ST_ADDR) || (state_reg == DMP_ST_READ)
                || (state_reg == DMP_ST_WRITE);
            hold_request <= hold_req_next;
            channel_acknowledge <= ~ack_active_high
                ^ ((active && !mem_to_mem_enable) ? one_hot(chan_reg) : 4'h0_000);
            upper_address_enable <= active;
            upper_address_strobe <= (state_reg == DMP_ST_ADDR);
            memory_read_n <= !(state_reg == DMP_ST_READ
                && (xfer_type == DMP_XFER_READ
                || (mem_to_mem_enable && src_phase_reg == 2'd0)));
            memory_write_n <= !(state_reg == DMP_ST_WRITE
                && (xfer_type == DMP_XFER_WRITE
                || (mem_to_mem_enable && src_phase_reg == 2'd1)));
            control_oe <= active;
            low_address_lines_out <= xfer_addr[3:0];
            low_address_lines_oe <= active;
            mid_address_lines <= xfer_addr[7:4];
            mid_address_lines_oe <= active;
            if (state_reg == DMP_ST_ADDR) begin
                data_lines_out <= xfer_addr[15:8];
            end else begin
                data_lines_out <= tmp_out.data;
            end
            data_lines_oe <= (state_reg == DMP_ST_ADDR)
                || (state_reg == DMP_ST_WRITE && mem_to_mem_enable && src_phase_reg == 2'd1);
            register_select <= low_address_lines_in;
            busy <= active;
        end
    end

    assign mask_status = mask_reg;
    assign terminal_count = tc_reg;
endmodule // dmp_bus_master

// ---- test/dmp_bus_master_props.sv ----
`timescale 1ns/100ps
module dmp_bus_master_props (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] channel_request,
    input wire logic [3:0] software_request,
    input wire logic [3:0] mask_status,
    input wire dmp_pkg::dmp_xfer_type xfer_type,
    input wire logic hold_request,
    input wire logic hold_acknowledge,
    input wire logic upper_address_enable,
    input wire logic upper_address_strobe,
    input wire logic data_lines_oe,
    input wire logic end_of_process_n_oe,
    input wire logic end_of_process_n_out,
    input wire logic control_oe,
    input wire logic low_address_lines_oe,
    input wire logic mid_address_lines_oe,
    input wire logic memory_read_n,
    input wire logic memory_write_n
);
    import dmp_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // ========
    // Checks
    a_hold_cause: assert property ($rose(hold_request) |->
        $past(|((channel_request & ~mask_status) | software_request))) else $error("bad hold");
    a_grant_first: assert property ($rose(upper_address_enable) |-> $past(hold_acknowledge))
        else $error("bus driven before grant");
    a_eop_drain: assert property (end_of_process_n_oe |-> !end_of_process_n_out)
        else $error("eop driven high");
    a_eop_pulse: assert property (end_of_process_n_oe |=> !end_of_process_n_oe)
        else $error("eop pulse too long");
    a_idle_quiet: assert property (!hold_request && !$past(hold_request) |->
        !(control_oe || low_address_lines_oe || mid_address_lines_oe)) else $error("idle drive");
    a_strobe_pulse: assert property (upper_address_strobe |=> !upper_address_strobe)
        else $error("strobe too long");
    a_upper_data: assert property (upper_address_strobe |-> data_lines_oe && upper_address_enable)
        else $error("strobe without upper byte");
    a_read_kind: assert property (!memory_read_n |-> control_oe &&
        xfer_type inside {DMP_XFER_READ, DMP_XFER_MEM2MEM}) else $error("bad read");
    a_write_kind: assert property (!memory_write_n |-> control_oe &&
        xfer_type inside {DMP_XFER_WRITE, DMP_XFER_MEM2MEM}) else $error("bad write");
    a_addr_grant: assert property ($rose(low_address_lines_oe) |->
        mid_address_lines_oe && hold_acknowledge) else $error("address lines misdriven");
    c_eop: cover property (end_of_process_n_oe);
    c_write: cover property (!memory_write_n);
    c_strobe: cover property (upper_address_strobe);
endmodule // dmp_bus_master_props
bind dmp_bus_master dmp_bus_master_props u_props (.core_clk, .rst_b, .channel_request,
    .software_request, .mask_status, .xfer_type, .hold_request, .hold_acknowledge,
    .upper_address_enable, .upper_address_strobe, .data_lines_oe, .end_of_process_n_oe,
    .end_of_process_n_out, .control_oe, .low_address_lines_oe, .mid_address_lines_oe,
    .memory_read_n, .memory_write_n);

// ---- test/dmp_host_model.sv ----
`timescale 1ns/100ps
module dmp_host_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] hack_delay,
    input wire logic hold_request,
    output logic hold_acknowledge,
    input wire logic ext_eop,
    input wire logic eop_oe,
    input wire logic eop_out,
    output logic eop_wire,
    input wire logic read_n,
    output logic [7:0] mem_data,
    output logic [3:0] host_addr
);
    logic [3:0] wait_reg;
    logic [7:0] pat_reg;
    // ========
    // Bus grant, delay zero ties it to the request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 4'h0;
        end else if (!hold_request) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hf) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    assign hold_acknowledge = hold_request && (wait_reg >= hack_delay);
    // ========
    // Released lines change every cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pat_reg <= 8'h00;
        end else begin
            pat_reg <= pat_reg + 8'h3b;
        end
    end
    assign mem_data = read_n ? ~pat_reg : 8'ha5;
    assign host_addr = pat_reg[3:0];
    // ========
    // Open-drain line with pull-up
    assign eop_wire = !((eop_oe && !eop_out) || ext_eop);
endmodule // dmp_host_model

// ---- test/tb_dmp_bus_master.sv ----
`timescale 1ns/100ps
module tb_dmp_bus_master;
    import dmp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] channel_request, software_request, mask_set, mask_clear, autoinit_enable;
    logic [3:0] ack_active_high, status_clear, low_address_lines_in, low_address_lines_out;
    logic [3:0] mid_address_lines, channel_acknowledge, register_select, mask_status;
    logic [3:0] terminal_count, hack_delay, host_addr, exp_sel, ack_seen;
    logic mem_to_mem_enable, block_mode, base_load, hold_acknowledge, end_of_process_n_in;
    logic end_of_process_n_oe, end_of_process_n_out, low_address_lines_oe, data_lines_oe;
    logic mid_address_lines_oe, hold_request, upper_address_enable, upper_address_strobe;
    logic memory_read_n, memory_write_n, control_oe, busy, ext_eop;
    logic [1:0] base_channel;
    logic [15:0] base_address, base_count;
    logic [7:0] data_lines_in, data_lines_out, mem_data, first_up, first_low, wr_data;
    dmp_xfer_type xfer_type;
    int num_errors = 0;
    int comparisons = 0;
    int n_rd, n_wr, n_stb, n_eop, gap;
    // ========
    // Wiring
    always #2 core_clk = ~core_clk;
    assign low_address_lines_in = low_address_lines_oe ? low_address_lines_out : host_addr;
    assign data_lines_in = data_lines_oe ? data_lines_out : mem_data;
    dmp_bus_master DUT (.*);
    dmp_host_model u_host (.core_clk, .rst_b, .hack_delay, .hold_request, .hold_acknowledge,
        .ext_eop, .eop_oe(end_of_process_n_oe), .eop_out(end_of_process_n_out),
        .eop_wire(end_of_process_n_in), .read_n(memory_read_n), .mem_data, .host_addr);
    // ========
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic load(input logic [1:0] ch, input logic [15:0] adr, input logic [15:0] cnt);
        base_channel <= ch;
        base_address <= adr;
        base_count <= cnt;
        base_load <= 1'b1;
        tick(1);
        base_load <= 1'b0;
        tick(1);
    endtask
    task automatic watch(input int lim);
        logic seen, aen_seen, low_seen;
        {seen, aen_seen, low_seen, ack_seen, wr_data} = '0;
        {n_rd, n_wr, n_stb, n_eop, gap} = '0;
        for (int k = 0; k < lim; k++) begin
            @(posedge core_clk);
            #1;
            aen_seen |= upper_address_enable;
            gap += int'(hold_request && !aen_seen);
            if (!low_seen) first_low = {mid_address_lines, low_address_lines_out};
            low_seen |= low_address_lines_oe;
            if (n_stb == 0) first_up = data_lines_out;
            n_stb += int'(upper_address_strobe);
            n_rd += int'(!memory_read_n);
            n_wr += int'(!memory_write_n);
            if (!memory_write_n && data_lines_oe) wr_data = data_lines_out;
            n_eop += int'(end_of_process_n_oe);
            if (control_oe) ack_seen |= ~(channel_acknowledge ^ ack_active_high);
            seen |= busy;
            if (seen && !busy && !hold_request) return;
        end
        check("service end", 16'h0001, 16'h0000);
        summarize;
    endtask
    // ========
    // Scenarios
    task automatic t_reset;
        check("mask", 16'h000f, 16'(mask_status));
        check("tc", 16'h0000, 16'(terminal_count));
        check("ack", 16'h000f, 16'(channel_acknowledge));
        check("hreq", 16'h0000, 16'(hold_request));
        check("oe", 16'h0000, 16'({control_oe, low_address_lines_oe}));
    endtask
    task automatic t_masked;
        channel_request <= 4'h4;
        tick(6);
        check("masked hreq", 16'h0000, 16'(hold_request));
        channel_request <= 4'h0;
        @(negedge core_clk);
        exp_sel = host_addr;
        @(posedge core_clk);
        #1;
        check("regsel", 16'(exp_sel), 16'(register_select));
    endtask
    task automatic t_kinds;
        for (int i = 0; i < 3; i++) begin
            xfer_type <= dmp_xfer_type'(i);
            ack_active_high <= 4'(i << 1);
            load(2'd1, 16'h1280, 16'h0001);
            mask_clear <= 4'h2;
            tick(1);
            mask_clear <= 4'h0;
            channel_request <= 4'h2;
            watch(200);
            channel_request <= 4'h0;
            check("reads", (i == 2) ? 16'h0002 : 16'h0000, 16'(n_rd));
            check("writes", (i == 1) ? 16'h0002 : 16'h0000, 16'(n_wr));
            check("eop", 16'h0001, 16'(n_eop));
            check("strobes", 16'h0001, 16'(n_stb));
            check("low addr", 16'h0080, 16'(first_low));
            check("upper", 16'h0012, 16'(first_up));
            check("ack", 16'h0002, 16'(ack_seen));
            check("gap", 16'h0002, 16'(gap));
            check("tc", 16'h0002, 16'(terminal_count));
            check("mask", 16'h000f, 16'(mask_status));
            status_clear <= 4'h2;
            tick(1);
            status_clear <= 4'h0;
            tick(1);
            check("tc clear", 16'h0000, 16'(terminal_count));
        end
    endtask
    task automatic t_m2m;
        mem_to_mem_enable <= 1'b1;
        xfer_type <= DMP_XFER_MEM2MEM;
        hack_delay <= 4'h5;
        load(2'd0, 16'h3400, 16'h0000);
        load(2'd1, 16'h5600, 16'h0000);
        software_request <= 4'h1;
        tick(1);
        software_request <= 4'h0;
        watch(200);
        check("m2m eop", 16'h0001, 16'(n_eop));
        check("m2m rd", 16'h0001, 16'(n_rd));
        check("m2m wr", 16'h0001, 16'(n_wr));
        check("m2m data", 16'h00a5, 16'(wr_data));
        check("m2m tc1", 16'h0001, 16'(terminal_count[1]));
        check("slow grant", 16'h0001, 16'(gap >= 5));
        mem_to_mem_enable <= 1'b0;
        hack_delay <= 4'h0;
    endtask
    task automatic t_abort;
        xfer_type <= DMP_XFER_READ;
        autoinit_enable <= 4'h8;
        load(2'd3, 16'h4565, 16'h00ff);
        mask_clear <= 4'h8;
        tick(1);
        mask_clear <= 4'h0;
        for (int r = 0; r < 2; r++) begin
            channel_request <= 4'h8;
            fork
                watch(300);
                begin
                    tick(12);
                    ext_eop <= 1'b1;
                    channel_request <= 4'h0;
                    tick(3);
                    ext_eop <= 1'b0;
                end
            join
            check("abort early", 16'h0001, 16'(n_rd < 16));
            check("reload", 16'h0065, 16'(first_low));
            check("abort tc", 16'h0008, 16'(terminal_count & 4'h8));
            check("abort mask", 16'h0000, 16'(mask_status & 4'h8));
        end
    endtask
    initial begin
        {channel_request, software_request, mask_set, mask_clear, autoinit_enable} = '0;
        {ack_active_high, status_clear, hack_delay, base_channel} = '0;
        {mem_to_mem_enable, base_load, ext_eop, base_address, base_count} = '0;
        block_mode = 1'b1;
        xfer_type = DMP_XFER_READ;
        tick(5);
        rst_b <= 1'b1;
        tick(1);
        t_reset;
        t_masked;
        t_kinds;
        t_m2m;
        t_abort;
        summarize;
    end
endmodule // tb_dmp_bus_master
